// File: frw_top.sv
// Summary of operation
// - 1k: remap moves window into low 4k
// - 512: remap picks eight windows at 01F000
// - 1k upper four bits ignore writes
// - 1k bit zero stores and reads back
// - Error flag reads zero after reset
// - Error flag set blocks program and erase
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps

module frw_top
	import frw_pkg::*;
#(
	parameter bit SMALL_WINDOWS = 1'b0, // 1 selects the 512-byte variant
	parameter int AW = 12, // AXI address width
	parameter logic [23:0] FLASH_TOP = 24'h01FFFF // Last flash byte
) (
	input wire logic clk, // System clock, 10 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire frw_pkg::frw_cpu_req_t cpuReq, // CPU access to decode
	output frw_pkg::frw_route_t cpuRoute, // Registered decode result
	input wire logic flashErrorDetect, // Pulse: flash controller saw an error
	input wire logic flashProgReq, // Program or erase request
	output logic flashProgGrant, // Program or erase allowed
	output logic irq // Level interrupt
);
	import frw_pkg::*;

	typedef enum {
		FRW_REG_CTRL_1K,
		FRW_REG_CTRL_512,
		FRW_REG_STATUS,
		FRW_REG_CLEAR,
		FRW_REG_ENABLE,
		FRW_REG_NONE
	} frw_reg_t;

	// Decode of a byte address into a register; the inactive variant is unmapped
	function automatic frw_reg_t decodeReg(input logic [AW-1:0] a);
		frw_reg_t r;
		r = FRW_REG_NONE;
		if (a[1:0] == 2'h0) begin
			if (a[AW-1:2] == (AW-2)'(FRW_IDX_CTRL_1K) && !SMALL_WINDOWS) begin
				r = FRW_REG_CTRL_1K;
			end else if (a[AW-1:2] == (AW-2)'(FRW_IDX_CTRL_512) && SMALL_WINDOWS) begin
				r = FRW_REG_CTRL_512;
			end else if (a[AW-1:2] == (AW-2)'(FRW_IDX_STATUS)) begin
				r = FRW_REG_STATUS;
			end else if (a[AW-1:2] == (AW-2)'(FRW_IDX_CLEAR)) begin
				r = FRW_REG_CLEAR;
			end else if (a[AW-1:2] == (AW-2)'(FRW_IDX_ENABLE)) begin
				r = FRW_REG_ENABLE;
			end
		end
		return r;
	endfunction

	logic awHeld;
	logic wHeld;
	logic [AW-1:0] awAddr;
	logic [7:0] wByte;
	logic wLane0;
	logic wrFire;
	frw_reg_t wrReg;
	frw_reg_t rdReg;
	logic [3:0] ctrl1kLow;
	logic [6:0] ctrl512Low;
	logic errFlag;
	logic [FRW_EV_N-1:0] evStatus;
	logic [FRW_EV_N-1:0] evEnable;
	logic [FRW_EV_N-1:0] evSet;
	logic [FRW_EV_N-1:0] evClr;
	logic [7:0] ctrlView;
	logic remapOn;
	logic [2:0] winSel;
	logic blockedTry;
	frw_route_t next_route;

	// Channel readiness: one write and one read in flight at a time
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrFire = awHeld && wHeld && !s_axi_bvalid;
	assign wrReg = decodeReg(awAddr);
	assign rdReg = decodeReg(s_axi_araddr);

	// Write address capture; address and data may arrive in either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			awAddr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (wrFire) begin
			awHeld <= 1'b0;
		end
	end

	// Write data capture; only the low byte lane carries register bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wHeld <= 1'b0;
			wByte <= 8'h00;
			wLane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wByte <= s_axi_wdata[7:0];
			wLane0 <= s_axi_wstrb[0];
		end else if (wrFire) begin
			wHeld <= 1'b0;
		end
	end

	// Write response, one cycle after both halves are in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= FRW_RESP_OKAY;
		end else if (wrFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wrReg == FRW_REG_NONE) ? FRW_RESP_SLVERR : FRW_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// 1k control: only bits 3..0 are storage, the top nibble is wired high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1kLow <= FRW_RST_CTRL_1K[3:0];
		end else if (wrFire && wLane0 && wrReg == FRW_REG_CTRL_1K) begin
			ctrl1kLow <= wByte[3:0];
		end
	end

	// 512 control: bit 7 is the hardware-owned error flag, the rest is storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl512Low <= FRW_RST_CTRL_512[6:0];
		end else if (wrFire && wLane0 && wrReg == FRW_REG_CTRL_512) begin
			ctrl512Low <= wByte[6:0];
		end
	end

	// Error flag: set by the flash controller, cleared only by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			errFlag <= FRW_RST_CTRL_512[FRW_BIT_ERRFLAG];
		end else if (SMALL_WINDOWS && flashErrorDetect) begin
			errFlag <= 1'b1;
		end
	end

	// Program and erase are gated off while in error-protect mode
	assign flashProgGrant = flashProgReq && !errFlag;
	assign blockedTry = flashProgReq && errFlag;

	// Control register as software sees it
	always_comb begin
		if (SMALL_WINDOWS) begin
			ctrlView = {errFlag, ctrl512Low};
		end else begin
			ctrlView = {FRW_FIXED_HI_1K, ctrl1kLow};
		end
	end

	assign remapOn = ctrlView[FRW_BIT_REMAP];
	assign winSel = ctrlView[FRW_BIT_SEL2:FRW_BIT_SEL0];

	// Address decode; the RAM leaves its home page while remapping is on
	always_comb begin
		next_route = '0;
		if (cpuReq.valid) begin
			if (SMALL_WINDOWS) begin
				if (remapOn && cpuReq.addr[23:12] == FRW_EMU_PAGE_512
					&& cpuReq.addr[11:9] == winSel) begin
					next_route.ramSel = 1'b1;
					next_route.emulated = 1'b1;
				end else if (!remapOn && cpuReq.addr[23:12] == FRW_RAM_HOME_PAGE
					&& cpuReq.addr[11:9] == 3'h0) begin
					next_route.ramSel = 1'b1;
				end
				next_route.ramOffset = {1'b0, cpuReq.addr[8:0]};
			end else begin
				if (remapOn && cpuReq.addr[23:12] == FRW_EMU_PAGE_1K
					&& cpuReq.addr[11:10] == winSel[2:1]) begin
					next_route.ramSel = 1'b1;
					next_route.emulated = 1'b1;
				end else if (!remapOn && cpuReq.addr[23:12] == FRW_RAM_HOME_PAGE
					&& cpuReq.addr[11:10] == 2'h0) begin
					next_route.ramSel = 1'b1;
				end
				next_route.ramOffset = cpuReq.addr[9:0];
			end
			// Flash only sees what the window did not take
			next_route.flashSel = !next_route.emulated && cpuReq.addr <= FLASH_TOP;
		end
	end

	// Decode result registered so the memory selects are glitch free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuRoute <= '0;
		end else begin
			cpuRoute <= next_route;
		end
	end

	// Event sources; the error event fires only on the flag's rising edge
	assign evSet[FRW_EV_ERRSET] = SMALL_WINDOWS && flashErrorDetect && !errFlag;
	assign evSet[FRW_EV_BLOCKED] = blockedTry;
	assign evSet[FRW_EV_EMUHIT] = next_route.emulated;
	assign evClr = (wrFire && wLane0 && wrReg == FRW_REG_CLEAR) ? wByte[FRW_EV_N-1:0] : '0;

	// Sticky status; a new event in the clearing cycle survives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evStatus <= '0;
		end else begin
			evStatus <= (evStatus & ~evClr) | evSet;
		end
	end

	// Interrupt enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evEnable <= '0;
		end else if (wrFire && wLane0 && wrReg == FRW_REG_ENABLE) begin
			evEnable <= wByte[FRW_EV_N-1:0];
		end
	end

	// Level interrupt, combinational so it drops with the clear write
	assign irq = |(evStatus & evEnable);

	// Read channel; data latched at the address handshake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= FRW_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= FRW_RESP_OKAY;
			unique case (rdReg)
				FRW_REG_CTRL_1K, FRW_REG_CTRL_512: begin
					s_axi_rdata <= {24'h000000, ctrlView};
				end
				FRW_REG_STATUS: begin
					s_axi_rdata <= {{(32-FRW_EV_N){1'b0}}, evStatus};
				end
				FRW_REG_ENABLE: begin
					s_axi_rdata <= {{(32-FRW_EV_N){1'b0}}, evEnable};
				end
				FRW_REG_CLEAR: begin
					s_axi_rdata <= 32'h0000_0000; // Write-only
				end
				FRW_REG_NONE: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= FRW_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // frw_top

// File: frw_pkg.sv
package frw_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] FRW_IDX_CTRL_1K = 8'h47;
	localparam logic [7:0] FRW_IDX_CTRL_512 = 8'h48;
	// Event, clear and enable registers placed above the control pair, from index 4C
	localparam logic [7:0] FRW_IDX_STATUS = 8'h4C;
	localparam logic [7:0] FRW_IDX_CLEAR = 8'h4D;
	localparam logic [7:0] FRW_IDX_ENABLE = 8'h4E;

	// Control register reset values
	localparam logic [7:0] FRW_RST_CTRL_1K = 8'hF0;
	localparam logic [7:0] FRW_RST_CTRL_512 = 8'h00;
	localparam logic [3:0] FRW_FIXED_HI_1K = 4'hF;

	// Control field positions (remap and select shared by both variants; error flag in the 512-byte variant only)
	localparam int FRW_BIT_REMAP = 3;
	localparam int FRW_BIT_SEL2 = 2;
	localparam int FRW_BIT_SEL1 = 1;
	localparam int FRW_BIT_SEL0 = 0;
	localparam int FRW_BIT_ERRFLAG = 7;

	// Address map of the windows
	localparam logic [11:0] FRW_RAM_HOME_PAGE = 12'hFFF;
	localparam logic [11:0] FRW_EMU_PAGE_1K = 12'h000;
	localparam logic [11:0] FRW_EMU_PAGE_512 = 12'h01F;

	// Event bit positions in status, clear and enable registers
	localparam int FRW_EV_ERRSET = 0;
	localparam int FRW_EV_BLOCKED = 1;
	localparam int FRW_EV_EMUHIT = 2;
	localparam int FRW_EV_N = 3;

	// AXI4-Lite response codes
	localparam logic [1:0] FRW_RESP_OKAY = 2'h0;
	localparam logic [1:0] FRW_RESP_SLVERR = 2'h2;

	// CPU access as it reaches the decoder
	typedef struct packed {
		logic valid;
		logic [23:0] addr;
	} frw_cpu_req_t;

	// Where the decoder sends the access
	typedef struct packed {
		logic ramSel;
		logic flashSel;
		logic emulated;
		logic [9:0] ramOffset;
	} frw_route_t;

endpackage

// File: frw_properties.sv
`timescale 1ns/1ps
// Watches decode results and flash protection at the top ports
module frw_properties
	import frw_pkg::*;
#(
	parameter bit SMALL_WINDOWS = 1'b0 // 1 selects the 512-byte variant
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Reset, active low
	input wire frw_pkg::frw_cpu_req_t cpuReq, // CPU access
	input wire frw_pkg::frw_route_t cpuRoute, // Decode result
	input wire logic flashErrorDetect, // Flash error seen
	input wire logic flashProgReq, // Program request
	input wire logic flashProgGrant // Program allowed
);
	import frw_pkg::*;
	localparam logic [11:0] EMU_PAGE = SMALL_WINDOWS ? FRW_EMU_PAGE_512 : FRW_EMU_PAGE_1K;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// The flag only clears on reset, so a long quiet stretch must follow
	sequence errSeen;
		SMALL_WINDOWS && flashErrorDetect ##1 1'h1;
	endsequence
	chk_err_blocks: assert property (errSeen |=> (!flashProgGrant) [*8])
		else $error("grant after flash error");
	chk_grant_req: assert property (flashProgGrant |-> flashProgReq)
		else $error("grant without request");
	chk_idle_route: assert property (!$past(cpuReq.valid) |-> !cpuRoute.ramSel && !cpuRoute.flashSel)
		else $error("route without access");
	chk_emu_ram: assert property (cpuRoute.emulated |-> cpuRoute.ramSel && !cpuRoute.flashSel)
		else $error("emulated access not in ram");
	chk_emu_page: assert property (cpuRoute.emulated |-> $past(cpuReq.addr[23:12]) == EMU_PAGE)
		else $error("emulated access off page");
	chk_emu_off: assert property (SMALL_WINDOWS && cpuRoute.emulated |->
		cpuRoute.ramOffset == {1'h0, $past(cpuReq.addr[8:0])})
		else $error("bad ram offset");
	chk_flash_top: assert property ($past(cpuReq.addr) > 24'h01FFFF |-> !cpuRoute.flashSel)
		else $error("flash selected above top");
	chk_home_ram: assert property (cpuRoute.ramSel && !cpuRoute.emulated |->
		$past(cpuReq.addr[23:12]) == FRW_RAM_HOME_PAGE)
		else $error("ram selected off home page");
endmodule // frw_properties

bind frw_top frw_properties #(.SMALL_WINDOWS(SMALL_WINDOWS)) chk_u (.clk, .rst_n, .cpuReq,
	.cpuRoute, .flashErrorDetect, .flashProgReq, .flashProgGrant);

// File: frw_cpu_model.sv
`timescale 1ns/1ps
// Stands in for the CPU address bus
module frw_cpu_model (
	input wire logic clk, // System clock
	output frw_pkg::frw_cpu_req_t cpuReq // Access to the decoder
);
	import frw_pkg::*;
	initial cpuReq = '0;
	// One access for one cycle; the address flips after so stale values never match
	task automatic access(input logic [23:0] a);
		@(posedge clk);
		cpuReq <= '{1'h1, a};
		@(posedge clk);
		cpuReq <= '{1'h0, ~a};
	endtask
endmodule // frw_cpu_model

// File: frw_top_bench.sv
`timescale 1ns/1ps
// Runs the 512-byte variant through registers, decode and protection
module frw_top_bench;
	import frw_pkg::*;
	localparam logic [11:0] A_CTRL = {2'h0, FRW_IDX_CTRL_512, 2'h0};
	localparam logic [11:0] A_1K = {2'h0, FRW_IDX_CTRL_1K, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, FRW_IDX_STATUS, 2'h0};
	localparam logic [11:0] A_CLR = {2'h0, FRW_IDX_CLEAR, 2'h0};
	localparam logic [11:0] A_EN = {2'h0, FRW_IDX_ENABLE, 2'h0};
	logic clk = '0;
	logic rst_n = '0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, flashErrorDetect = '0, flashProgReq = '1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic irq, flashProgGrant;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	frw_cpu_req_t cpuReq;
	frw_route_t cpuRoute;
	int n_fail = 0, n_tests = 0, cycles = 0;
	frw_top #(.SMALL_WINDOWS(1'h1)) dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpuReq, .cpuRoute, .flashErrorDetect,
		.flashProgReq, .flashProgGrant, .irq);
	frw_cpu_model cpu_u (.clk, .cpuReq);
	// Clock, 100 ns period
	initial begin
		forever #50 clk = ~clk;
	end
	// Cuts a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test;
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Each half is released once taken; the answer is awaited without assuming a latency
	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// Offset is only meaningful when RAM is selected
	task automatic cpu(input logic [23:0] a, input frw_route_t exp);
		frw_route_t got;
		cpu_u.access(a);
		#1;
		got = cpuRoute;
		if (!exp.ramSel) got.ramOffset = exp.ramOffset;
		chk("route", 32'(exp), 32'(got));
	endtask
	task automatic t_reset;
		axi_rd(A_CTRL, rdv, rr);
		chk("ctrl reset", 32'h00000000, rdv);
		axi_rd(A_1K, rdv, rr);
		chk("unmapped", 32'(FRW_RESP_SLVERR), 32'(rr));
		// Upper nibble left clear so the reserved bits are never written
		axi_wr(A_1K, 8'h0F, rr);
		chk("unmapped wr", 32'(FRW_RESP_SLVERR), 32'(rr));
		chk("grant open", 32'h1, 32'(flashProgGrant));
	endtask
	task automatic t_home;
		cpu(24'hFFF000, '{1'h1, 1'h0, 1'h0, 10'h000});
		cpu(24'hFFF1FF, '{1'h1, 1'h0, 1'h0, 10'h1FF});
		cpu(24'hFFF200, '{1'h0, 1'h0, 1'h0, 10'h000});
		cpu(24'h01F000, '{1'h0, 1'h1, 1'h0, 10'h000});
	endtask
	task automatic t_windows;
		for (int s = 0; s < 8; s++) begin
			axi_wr(A_CTRL, 8'h08 | 8'(s), rr);
			chk("bresp", 32'(FRW_RESP_OKAY), 32'(rr));
			axi_rd(A_CTRL, rdv, rr);
			chk("ctrl", 32'h8 | 32'(s), rdv);
			cpu(24'h01F005 + 24'(s) * 24'h200, '{1'h1, 1'h0, 1'h1, 10'h005});
			cpu(24'h01F005 + 24'(s ^ 1) * 24'h200, '{1'h0, 1'h1, 1'h0, 10'h000});
		end
	endtask
	task automatic t_irq;
		axi_wr(A_CLR, 8'h07, rr);
		axi_wr(A_EN, 8'h04, rr);
		chk("irq idle", 32'h0, 32'(irq));
		cpu(24'h01FE10, '{1'h1, 1'h0, 1'h1, 10'h010});
		chk("irq hit", 32'h1, 32'(irq));
		axi_rd(A_STAT, rdv, rr);
		chk("status", 32'h4, rdv & 32'h4);
		axi_wr(A_CLR, 8'h04, rr);
		chk("irq clear", 32'h0, 32'(irq));
	endtask
	task automatic t_error;
		@(posedge clk);
		flashErrorDetect <= 1'h1;
		@(posedge clk);
		flashErrorDetect <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk("grant shut", 32'h0, 32'(flashProgGrant));
		axi_wr(A_CTRL, 8'h00, rr);
		axi_rd(A_CTRL, rdv, rr);
		chk("flag", 32'h80, rdv);
		// Error event and blocked request both latched; no emulated hit since the clear
		axi_rd(A_STAT, rdv, rr);
		chk("err events", 32'h3, rdv);
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		t_reset;
		t_home;
		t_windows;
		t_irq;
		t_error;
		end_of_test;
	end
endmodule // frw_top_bench
